// file: verilog/seek_ctl_pkg.sv
// Constants shared by the head positioning controller and its stepper.
// Assumes a 10 MHz controller clock and byte-addressed Avalon-MM access.
package seek_ctl_pkg;

  // Clock and timing
  localparam int CLK_HZ = 10000000;
  localparam int STEP_UNIT_US = 1000;
  localparam int STEP_UNIT_CYCLES = STEP_UNIT_US * (CLK_HZ / 1000000);
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_PULSE_CYCLES =
    (STEP_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int RATE_W = 4;
  localparam logic [4:0] RATE_SPAN = 5'h10;

  // Register byte offsets
  localparam logic [4:0] OFS_CMD = 5'h00;
  localparam logic [4:0] OFS_TARGET = 5'h04;
  localparam logic [4:0] OFS_RATE = 5'h08;
  localparam logic [4:0] OFS_STATUS0 = 5'h0C;
  localparam logic [4:0] OFS_STATUS1 = 5'h10;
  localparam logic [4:0] OFS_CYL = 5'h14;
  localparam logic [4:0] OFS_IDENT = 5'h18;
  localparam logic [4:0] OFS_FLAGS = 5'h1C;

  // Command codes in the low bits of the command register
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_SEEK = 3'h1,
    CMD_RECAL = 3'h2,
    CMD_READ_ID = 3'h3,
    CMD_SENSE = 3'h4,
    CMD_POWER_DOWN = 3'h5,
    CMD_WAKE = 3'h6
  } cmd_type;

  // Interrupt codes
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;

  // Recalibrate gives up after this many steps
  localparam logic [6:0] RECAL_MAX_STEPS = 7'h4F;
  // Index pulses allowed while hunting for an identifier mark
  localparam logic [1:0] INDEX_LIMIT = 2'h2;

  // Flags register bit positions
  localparam int FLAG_BUSY = 0;
  localparam int FLAG_INT = 1;
  localparam int FLAG_DOWN = 2;
  localparam int FLAG_RUN = 3;

  // Single-density track preamble
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [7:0] SYNC_BYTE = 8'h00;
  localparam logic [7:0] INDEX_MARK = 8'hFC;
  localparam logic [7:0] IDENT_MARK = 8'hFE;
  localparam logic [7:0] DATA_MARK = 8'hFB;
  localparam logic [7:0] DELETED_MARK = 8'hF8;
  localparam logic [5:0] GAP4A_LEN = 6'h28;
  localparam logic [5:0] GAP1_LEN = 6'h1A;
  localparam logic [5:0] SYNC_LEN = 6'h06;
  localparam logic [5:0] MARK_LEN = 6'h01;
  localparam logic [2:0] SEG_LAST = 3'h5;

endpackage

// file: verilog/step_pulser.sv
// Step pulse timer for the drive's step line.
// Assumes run_i is held by the controller for the whole positioning move.
module step_pulser #(
  parameter int UNIT_CYCLES = seek_ctl_pkg::STEP_UNIT_CYCLES,
  parameter int PULSE_CYCLES = seek_ctl_pkg::STEP_PULSE_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [seek_ctl_pkg::RATE_W-1:0] rate_i,
  // Drive step line and completion strobe
  output logic step_o,
  output logic stepped_o
);

  logic [23:0] wait_q;
  logic [15:0] width_q;
  logic step_q;
  logic first_q;
  logic stepped_q;
  logic [23:0] gap_full;
  logic [23:0] gap_next;

  // Higher setting means shorter spacing
  assign gap_full = 24'(({19'h0, seek_ctl_pkg::RATE_SPAN} - 24'(rate_i))
                    * 24'(UNIT_CYCLES));
  // First gap is halved, as a real mechanism allows
  assign gap_next = first_q ? (gap_full >> 1) : gap_full;
  assign step_o = step_q;
  assign stepped_o = stepped_q;

  // Pulse, then wait out the spacing; a started pulse runs full width unless rst_i cuts it short
  always_ff @(posedge mclk_i) begin
    if (rst_i || (!run_i && !step_q)) begin
      wait_q <= 24'h0;
      width_q <= 16'h0;
      step_q <= 1'b0;
      first_q <= 1'b1;
      stepped_q <= 1'b0;
    end else begin
      stepped_q <= 1'b0;
      if (step_q) begin
        if (width_q == 16'(PULSE_CYCLES - 1)) begin
          step_q <= 1'b0;
          stepped_q <= 1'b1;
          wait_q <= gap_next;
          first_q <= 1'b0;
          width_q <= 16'h0;
        end else begin
          width_q <= width_q + 16'h1;
        end
      end else if (wait_q != 24'h0) begin
        wait_q <= wait_q - 24'h1;
      end else if (!stepped_q) begin
        step_q <= 1'b1; // Owner may end the move first
      end
    end
  end

endmodule

// file: verilog/head_position_ctl.sv
// Head positioning and control commands of a floppy controller, with
// an Avalon-MM register slave and a single-density preamble source.
// Assumes drive pins are asynchronous and the identifier decoder runs
// on mclk_i.
//
// How it works
// - Only seek, recal, read-id raise interrupts
// - Read-id latches first good identifier field
// - Two index pulses without mark: abnormal end
// - Recal clears cylinder, watches track zero
// - Recal steps outward while track zero low
// - Track zero high ends recal, seek-end set
// - 79 steps without track zero: equipment check
// - Busy only while a command is written
// - Target above present: step inward
// - Target below present: step outward
// - Step spacing follows step-rate setting
// - Compare after each step; equal ends seek
// - Head bit in status zero reads zero
// - Wake-up clears cylinder and all status
// - Preamble fill, sync and mark bytes
// - Sense reports code 00 normal, 01 abnormal
// - First step gap may be shorter
//
// Added by the designer: the address map and the Avalon-MM register port.
module head_position_ctl #(
  parameter int STEP_UNIT_CYCLES = seek_ctl_pkg::STEP_UNIT_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Drive pins
  input wire logic track_zero_in_i,
  input wire logic index_pulse_in_i,
  output logic step_o,
  output logic direction_o,
  // Identifier fields from the read channel
  input wire logic id_found_i,
  input wire logic [7:0] id_cyl_i,
  input wire logic [7:0] id_head_i,
  input wire logic [7:0] id_sec_i,
  input wire logic [7:0] id_size_i,
  // Preamble byte stream for formatting
  input wire logic fmt_start_i,
  input wire logic fmt_ready_i,
  output logic [7:0] fmt_byte_o,
  output logic fmt_valid_o,
  // Status outputs
  output logic busy_o,
  output logic controller_interrupt_o
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEEK = 2'b01,
    ST_RECAL = 2'b10,
    ST_READ_ID = 2'b11
  } state_type;

  state_type state_q, state_d;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [7:0] target_cylinder_q;
  logic [7:0] present_cylinder_q, present_cylinder_d;
  logic [3:0] step_rate_setting_q;
  logic [1:0] interrupt_code_q, interrupt_code_d;
  logic positioning_done_flag_q, positioning_done_flag_d;
  logic equipment_check_flag_q, equipment_check_flag_d;
  logic absent_mark_flag_q, absent_mark_flag_d;
  logic int_q;
  logic down_q;
  logic dir_q, dir_d;
  logic [6:0] steps_q;
  logic [1:0] index_cnt_q;
  logic [31:0] ident_q;
  logic tz_s1_q, tz_s2_q;
  logic ix_s1_q, ix_s2_q, ix_s3_q;
  logic [2:0] seg_q;
  logic [5:0] seg_cnt_q;
  logic fmt_on_q;

  logic access, wr_en, rd_take;
  logic cmd_wr;
  logic [2:0] cmd_code;
  logic stepped;
  logic index_edge;
  logic finish;
  logic [7:0] status_zero;
  logic [31:0] rd_mux;
  logic [7:0] cyl_next;

  // Bus handshake: every access is answered on its second edge
  assign access = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = access & ~ack_q;
  assign wr_en = avs_write_i & ack_q & avs_byteenable_i[0];
  assign rd_take = avs_read_i & ~ack_q;
  assign avs_readdata_o = rdata_q;
  assign cmd_wr = wr_en && avs_address_i == seek_ctl_pkg::OFS_CMD;
  assign cmd_code = avs_writedata_i[2:0];

  assign busy_o = avs_write_i && avs_address_i == seek_ctl_pkg::OFS_CMD;

  assign status_zero = {interrupt_code_q, positioning_done_flag_q,
                        equipment_check_flag_q, 4'h0};

  // Register read selection; unmapped offsets read as zero
  assign rd_mux =
    avs_address_i == seek_ctl_pkg::OFS_TARGET ? {24'h0, target_cylinder_q} :
    avs_address_i == seek_ctl_pkg::OFS_RATE ? {28'h0, step_rate_setting_q} :
    avs_address_i == seek_ctl_pkg::OFS_STATUS0 ? {24'h0, status_zero} :
    avs_address_i == seek_ctl_pkg::OFS_STATUS1 ?
      {31'h0, absent_mark_flag_q} :
    avs_address_i == seek_ctl_pkg::OFS_CYL ? {24'h0, present_cylinder_q} :
    avs_address_i == seek_ctl_pkg::OFS_IDENT ? ident_q :
    avs_address_i == seek_ctl_pkg::OFS_FLAGS ?
      {28'h0, state_q != ST_IDLE, down_q, int_q, busy_o} :
    32'h0;

  // Bus answer and read data
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= access & ~ack_q;
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Plain software settings
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      target_cylinder_q <= 8'h0;
      step_rate_setting_q <= 4'h0;
    end else if (wr_en) begin
      if (avs_address_i == seek_ctl_pkg::OFS_TARGET) begin
        target_cylinder_q <= avs_writedata_i[7:0];
      end
      if (avs_address_i == seek_ctl_pkg::OFS_RATE) begin
        step_rate_setting_q <= avs_writedata_i[3:0];
      end
    end
  end

  // Drive pins pass two flops before use
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tz_s1_q <= 1'b0;
      tz_s2_q <= 1'b0;
      ix_s1_q <= 1'b0;
      ix_s2_q <= 1'b0;
      ix_s3_q <= 1'b0;
    end else begin
      tz_s1_q <= track_zero_in_i;
      tz_s2_q <= tz_s1_q;
      ix_s1_q <= index_pulse_in_i;
      ix_s2_q <= ix_s1_q;
      ix_s3_q <= ix_s2_q;
    end
  end
  assign index_edge = ix_s2_q & ~ix_s3_q;

  step_pulser #(
    .UNIT_CYCLES(STEP_UNIT_CYCLES),
    .PULSE_CYCLES(seek_ctl_pkg::STEP_PULSE_CYCLES)
  ) u_step (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .run_i((state_q == ST_SEEK) || (state_q == ST_RECAL && !tz_s2_q)),
    .rate_i(step_rate_setting_q),
    .step_o(step_o),
    .stepped_o(stepped)
  );
  assign direction_o = dir_q;

  assign cyl_next = dir_q ? present_cylinder_q + 8'h1
                          : present_cylinder_q - 8'h1;

  // Command start, stepping and termination
  always_comb begin
    state_d = state_q;
    present_cylinder_d = present_cylinder_q;
    dir_d = dir_q;
    interrupt_code_d = interrupt_code_q;
    positioning_done_flag_d = positioning_done_flag_q;
    equipment_check_flag_d = equipment_check_flag_q;
    absent_mark_flag_d = absent_mark_flag_q;
    finish = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
      end
      ST_SEEK: begin
        if (stepped) begin
          present_cylinder_d = cyl_next;
          if (cyl_next == target_cylinder_q) begin
            positioning_done_flag_d = 1'b1;
            interrupt_code_d = seek_ctl_pkg::IC_NORMAL;
            finish = 1'b1;
            state_d = ST_IDLE;
          end
        end
      end
      ST_RECAL: begin
        // track zero ends recal, after the pulse
        if (tz_s2_q && !step_o) begin
          positioning_done_flag_d = 1'b1;
          interrupt_code_d = seek_ctl_pkg::IC_NORMAL;
          finish = 1'b1;
          state_d = ST_IDLE;
        end else if (stepped && steps_q == seek_ctl_pkg::RECAL_MAX_STEPS
                     - 7'h1) begin
          positioning_done_flag_d = 1'b1;
          equipment_check_flag_d = 1'b1;
          interrupt_code_d = seek_ctl_pkg::IC_ABNORMAL;
          finish = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_READ_ID: begin
        if (id_found_i) begin
          interrupt_code_d = seek_ctl_pkg::IC_NORMAL;
          finish = 1'b1;
          state_d = ST_IDLE;
        end else if (index_edge &&
                     index_cnt_q == seek_ctl_pkg::INDEX_LIMIT - 2'h1) begin
          interrupt_code_d = seek_ctl_pkg::IC_ABNORMAL;
          absent_mark_flag_d = 1'b1;
          finish = 1'b1;
          state_d = ST_IDLE;
        end
      end
    endcase
    // A new seek, recal, read-id or power-down command overrides a move in progress
    if (cmd_wr && !down_q) begin
      unique case (cmd_code)
        seek_ctl_pkg::CMD_SEEK: begin
          positioning_done_flag_d = 1'b0;
          equipment_check_flag_d = 1'b0;
          dir_d = present_cylinder_q < target_cylinder_q;
          if (present_cylinder_q == target_cylinder_q) begin
            positioning_done_flag_d = 1'b1;
            interrupt_code_d = seek_ctl_pkg::IC_NORMAL;
            finish = 1'b1;
            state_d = ST_IDLE;
          end else begin
            state_d = ST_SEEK;
          end
        end
        seek_ctl_pkg::CMD_RECAL: begin
          present_cylinder_d = 8'h0;
          positioning_done_flag_d = 1'b0;
          equipment_check_flag_d = 1'b0;
          dir_d = 1'b0;
          state_d = ST_RECAL;
        end
        seek_ctl_pkg::CMD_READ_ID: begin
          absent_mark_flag_d = 1'b0;
          state_d = ST_READ_ID;
        end
        seek_ctl_pkg::CMD_POWER_DOWN: begin
          state_d = ST_IDLE;
        end
        default: begin
        end
      endcase
    end
    if (cmd_wr && down_q && cmd_code == seek_ctl_pkg::CMD_WAKE) begin
      present_cylinder_d = 8'h0;
      interrupt_code_d = seek_ctl_pkg::IC_NORMAL;
      positioning_done_flag_d = 1'b0;
      equipment_check_flag_d = 1'b0;
      absent_mark_flag_d = 1'b0;
    end
  end

  // Controller state
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      present_cylinder_q <= 8'h0;
      dir_q <= 1'b0;
      interrupt_code_q <= seek_ctl_pkg::IC_NORMAL;
      positioning_done_flag_q <= 1'b0;
      equipment_check_flag_q <= 1'b0;
      absent_mark_flag_q <= 1'b0;
    end else begin
      state_q <= state_d;
      present_cylinder_q <= present_cylinder_d;
      dir_q <= dir_d;
      interrupt_code_q <= interrupt_code_d;
      positioning_done_flag_q <= positioning_done_flag_d;
      equipment_check_flag_q <= equipment_check_flag_d;
      absent_mark_flag_q <= absent_mark_flag_d;
    end
  end

  // Step and index counters, restarted by each command
  always_ff @(posedge mclk_i) begin
    if (rst_i || cmd_wr) begin
      steps_q <= 7'h0;
      index_cnt_q <= 2'h0;
    end else begin
      if (stepped) begin
        steps_q <= steps_q + 7'h1;
      end
      if (index_edge && state_q == ST_READ_ID) begin
        index_cnt_q <= index_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ident_q <= 32'h0;
    end else if (state_q == ST_READ_ID && id_found_i) begin
      ident_q <= {id_size_i, id_sec_i, id_head_i, id_cyl_i};
    end
  end

  // completion sets, sense clears; completion wins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      int_q <= 1'b0;
      down_q <= 1'b0;
    end else begin
      int_q <= finish |
        (int_q & ~(cmd_wr && cmd_code == seek_ctl_pkg::CMD_SENSE));
      if (cmd_wr && cmd_code == seek_ctl_pkg::CMD_POWER_DOWN) begin
        down_q <= 1'b1;
      end else if (cmd_wr && cmd_code == seek_ctl_pkg::CMD_WAKE) begin
        down_q <= 1'b0;
      end
    end
  end
  assign controller_interrupt_o = int_q;

  // Preamble segment table, read by the byte and length paths
  function automatic logic [7:0] seg_byte(input logic [2:0] seg);
    unique case (seg)
      3'h0, 3'h3: seg_byte = seek_ctl_pkg::FILL_BYTE;
      3'h2: seg_byte = seek_ctl_pkg::INDEX_MARK;
      3'h5: seg_byte = seek_ctl_pkg::IDENT_MARK;
      default: seg_byte = seek_ctl_pkg::SYNC_BYTE;
    endcase
  endfunction

  function automatic logic [5:0] seg_len(input logic [2:0] seg);
    unique case (seg)
      3'h0: seg_len = seek_ctl_pkg::GAP4A_LEN;
      3'h3: seg_len = seek_ctl_pkg::GAP1_LEN;
      3'h2, 3'h5: seg_len = seek_ctl_pkg::MARK_LEN;
      default: seg_len = seek_ctl_pkg::SYNC_LEN;
    endcase
  endfunction

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fmt_on_q <= 1'b0;
      seg_q <= 3'h0;
      seg_cnt_q <= 6'h0;
      fmt_byte_o <= 8'h0;
    end else if (!fmt_on_q) begin
      fmt_on_q <= fmt_start_i;
      seg_q <= 3'h0;
      seg_cnt_q <= 6'h0;
      fmt_byte_o <= seg_byte(3'h0);
    end else if (fmt_ready_i) begin
      if (seg_cnt_q == seg_len(seg_q) - 6'h1) begin
        seg_cnt_q <= 6'h0;
        seg_q <= seg_q + 3'h1;
        fmt_byte_o <= seg_byte(seg_q + 3'h1);
        fmt_on_q <= seg_q != seek_ctl_pkg::SEG_LAST;
      end else begin
        seg_cnt_q <= seg_cnt_q + 6'h1;
      end
    end
  end
  assign fmt_valid_o = fmt_on_q;

endmodule

// file: testbench/drive_model.sv
// Behavioural floppy drive: head position, track-zero and index lines.
// Assumes active-high step pulses and direction 1 meaning inward.
module drive_model (
  // Clock
  input wire logic mclk_i,
  // Bench controls
  input wire logic [7:0] load_pos_i,
  input wire logic load_i,
  input wire logic stuck_i,
  input wire logic index_en_i,
  // Drive pins
  input wire logic step_i,
  input wire logic direction_i,
  output logic track_zero_o,
  output logic index_o,
  output logic [7:0] pos_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic step_q = 1'b0;
  logic [5:0] tick_q = 6'h00;
  initial pos_o = 8'h00;
  // Head moves one track per step rise; outward stops at track 0
  always @(posedge mclk_i) begin
    step_q <= step_i;
    tick_q <= tick_q + 6'h01;
    if (load_i) begin
      pos_o <= load_pos_i;
    end else if (step_i && !step_q) begin
      if (direction_i) begin
        pos_o <= pos_o + 8'h01;
      end else if (pos_o != 8'h00) begin
        pos_o <= pos_o - 8'h01;
      end
    end
  end
  // Stuck sensor models a drive that never reports track zero
  assign track_zero_o = (pos_o == 8'h00) && !stuck_i;
  // Index: 4 of every 64 cycles, only while the disk spins
  assign index_o = index_en_i && (tick_q < 6'h04);
endmodule

// file: testbench/head_position_ctl_monitor.sv
// Port checker for the head positioning controller.
// Assumes it is bound into head_position_ctl; one clock domain.
module head_position_ctl_monitor (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // Drive and stream
  input wire logic step_o,
  input wire logic direction_o,
  input wire logic id_found_i,
  input wire logic fmt_ready_i,
  input wire logic [7:0] fmt_byte_o,
  input wire logic fmt_valid_o,
  // Status
  input wire logic busy_o,
  input wire logic controller_interrupt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Accepted sense command
  wire cmd_w = avs_write_i && avs_address_i == seek_ctl_pkg::OFS_CMD;
  wire sense_w = cmd_w && !avs_waitrequest_o && avs_byteenable_i[0] &&
    avs_writedata_i[2:0] == seek_ctl_pkg::CMD_SENSE;
  chk_step_width: assert property ($rose(step_o) |-> step_o[*8] ##1
    step_o ##1 step_o ##1 !step_o) else $error("step width wrong");
  chk_dir_settled: assert property ($rose(step_o) |->
    $stable(direction_o)) else $error("direction moved at step");
  chk_wait_one: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("wait too long");
  chk_idle_wait: assert property (!avs_read_i && !avs_write_i |->
    !avs_waitrequest_o) else $error("wait while idle");
  chk_busy_cmd: assert property (busy_o == cmd_w)
    else $error("busy outside command write");
  chk_irq_stop: assert property ($rose(controller_interrupt_o)
    |-> !step_o) else $error("stepping at completion");
  chk_sense_clear: assert property (sense_w && !step_o &&
    !id_found_i && !$past(step_o) && !$past(step_o, 2) |=>
    !controller_interrupt_o) else $error("sense left interrupt");
  chk_fmt_first: assert property ($rose(fmt_valid_o) |->
    fmt_byte_o == seek_ctl_pkg::FILL_BYTE) else $error("first byte");
  chk_fmt_hold: assert property (fmt_valid_o && !fmt_ready_i |=>
    fmt_valid_o && $stable(fmt_byte_o)) else $error("byte dropped");
  // Main scenarios reached
  cov_step: cover property ($rose(step_o));
  cov_irq: cover property ($rose(controller_interrupt_o));
  cov_sense: cover property (sense_w);
  cov_stall: cover property (fmt_valid_o && !fmt_ready_i);
endmodule

bind head_position_ctl head_position_ctl_monitor
  head_position_ctl_monitor_inst (
  .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .step_o(step_o),
  .direction_o(direction_o), .id_found_i(id_found_i),
  .fmt_ready_i(fmt_ready_i), .fmt_byte_o(fmt_byte_o),
  .fmt_valid_o(fmt_valid_o), .busy_o(busy_o),
  .controller_interrupt_o(controller_interrupt_o));

// file: testbench/floppy_head_seek_recal_control_test.sv
// Self-checking bench for the head positioning controller.
// Assumes the drive model and the bound port checker compile first.
module floppy_head_seek_recal_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UNIT = 2;
  typedef struct {logic [7:0] tgt; logic [3:0] rate; logic dir;} row_type;
  row_type rows [5] = '{'{8'h03, 4'hF, 1'b1}, '{8'h03, 4'hF, 1'b1},
    '{8'h01, 4'hE, 1'b0}, '{8'h06, 4'hD, 1'b1}, '{8'h00, 4'hF, 1'b0}};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hF;
  logic idf = 1'b0;
  logic [31:0] idv = 32'h0;
  logic fstart = 1'b0;
  logic fready = 1'b0;
  logic load = 1'b1;
  logic stuck = 1'b0;
  logic idx_en = 1'b0;
  logic [31:0] rdat, rv;
  logic wait_w, tz, idx, step, dir, irq, busy, fvalid, sdir;
  logic step_q = 1'b0;
  logic [7:0] fbyte, pos;
  int err_total = 0;
  int n_checks = 0;
  int nstep = 0;
  int cyc = 0;
  int last = 0;
  int per, ex, g, prev, k, t;
  head_position_ctl #(.STEP_UNIT_CYCLES(UNIT)) head_position_ctl_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_w), .track_zero_in_i(tz),
    .index_pulse_in_i(idx), .step_o(step), .direction_o(dir),
    .id_found_i(idf), .id_cyl_i(idv[7:0]), .id_head_i(idv[15:8]),
    .id_sec_i(idv[23:16]), .id_size_i(idv[31:24]),
    .fmt_start_i(fstart), .fmt_ready_i(fready), .fmt_byte_o(fbyte),
    .fmt_valid_o(fvalid), .busy_o(busy), .controller_interrupt_o(irq));
  drive_model drive_model_inst (.mclk_i(mclk_i), .load_pos_i(8'h05),
    .load_i(load), .stuck_i(stuck), .index_en_i(idx_en), .step_i(step),
    .direction_i(dir), .track_zero_o(tz), .index_o(idx), .pos_o(pos));
  // 10 MHz clock
  initial forever #50 mclk_i = ~mclk_i;
  // Step count, direction and latest step period
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    step_q <= step;
    if (step && !step_q) begin
      nstep <= nstep + 1;
      sdir <= dir;
      per <= cyc - last;
      last <= cyc;
    end
  end
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // One Avalon access; holds until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    @(posedge mclk_i);
    while (wait_w !== 1'b0 && n < 50) begin
      n++;
      @(posedge mclk_i);
    end
    if (n == 50) err_total++;
    rv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic cmd(input seek_ctl_pkg::cmd_type c);
    bus(1'b1, seek_ctl_pkg::OFS_CMD, 32'(c));
  endtask
  task automatic rdchk(input string nm, input logic [4:0] a,
      input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(nm, rv & mask, exp);
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      n++;
      @(posedge mclk_i);
    end
    check("irq", irq, 32'h1);
  endtask
  task automatic sense();
    cmd(seek_ctl_pkg::CMD_SENSE);
    rdchk("flags", seek_ctl_pkg::OFS_FLAGS, 32'h2, 32'h0);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #3000000;
    err_total++;
    results();
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    check("rst_irq", {step, irq}, 32'h0);
    rst_i <= 1'b0;
    load <= 1'b0;
    // Recalibrate first, head starts at track 5
    cmd(seek_ctl_pkg::CMD_RECAL);
    wait_irq();
    check("rc_steps", nstep, 32'd5);
    check("rc_dir", sdir, 32'h0);
    rdchk("rc_st0", seek_ctl_pkg::OFS_STATUS0, 32'hFF, 32'h20);
    rdchk("rc_cyl", seek_ctl_pkg::OFS_CYL, 32'hFF, 32'h0);
    sense();
    prev = 0;
    foreach (rows[i]) begin
      bus(1'b1, seek_ctl_pkg::OFS_RATE, {28'h0, rows[i].rate});
      bus(1'b1, seek_ctl_pkg::OFS_TARGET, {24'h0, rows[i].tgt});
      nstep = 0;
      ex = rows[i].tgt > prev ? rows[i].tgt - prev : prev - rows[i].tgt;
      g = 10 + (16 - rows[i].rate) * UNIT;
      cmd(seek_ctl_pkg::CMD_SEEK);
      rdchk("run", seek_ctl_pkg::OFS_FLAGS, 32'h9, ex ? 32'h8 : 32'h0);
      wait_irq();
      check("steps", nstep, ex);
      if (ex != 0) check("dir", sdir, rows[i].dir);
      if (ex > 2) check("gap", per >= g && per <= g + 1, 32'h1);
      rdchk("st0", seek_ctl_pkg::OFS_STATUS0, 32'hFF, 32'h20);
      rdchk("cyl", seek_ctl_pkg::OFS_CYL, 32'hFF, rows[i].tgt);
      check("head", pos, rows[i].tgt);
      sense();
      prev = rows[i].tgt;
    end
    // Drive never reports track zero
    stuck <= 1'b1;
    nstep = 0;
    cmd(seek_ctl_pkg::CMD_RECAL);
    wait_irq();
    check("rc_max", nstep, 32'd79);
    rdchk("rc_ec", seek_ctl_pkg::OFS_STATUS0, 32'hFF, 32'h70);
    sense();
    stuck <= 1'b0;
    // Two identifier fields back to back; first is kept
    cmd(seek_ctl_pkg::CMD_READ_ID);
    idf <= 1'b1;
    idv <= 32'h02070112;
    @(posedge mclk_i);
    idv <= 32'h03080213;
    @(posedge mclk_i);
    idf <= 1'b0;
    wait_irq();
    rdchk("id", seek_ctl_pkg::OFS_IDENT, 32'hFFFFFFFF, 32'h02070112);
    rdchk("id_ic", seek_ctl_pkg::OFS_STATUS0, 32'hC0, 32'h0);
    sense();
    // No mark before the second index pulse
    idx_en <= 1'b1;
    cmd(seek_ctl_pkg::CMD_READ_ID);
    wait_irq();
    rdchk("ma_ic", seek_ctl_pkg::OFS_STATUS0, 32'hC0, 32'h40);
    rdchk("ma", seek_ctl_pkg::OFS_STATUS1, 32'hFF, 32'h1);
    sense();
    idx_en <= 1'b0;
    // Power down from track 4, ignored seek, then wake
    bus(1'b1, seek_ctl_pkg::OFS_TARGET, 32'h4);
    cmd(seek_ctl_pkg::CMD_SEEK);
    wait_irq();
    sense();
    cmd(seek_ctl_pkg::CMD_POWER_DOWN);
    rdchk("down", seek_ctl_pkg::OFS_FLAGS, 32'hF, 32'h4);
    nstep = 0;
    bus(1'b1, seek_ctl_pkg::OFS_TARGET, 32'h9);
    cmd(seek_ctl_pkg::CMD_SEEK);
    repeat (30) @(posedge mclk_i);
    check("down_step", nstep, 32'h0);
    cmd(seek_ctl_pkg::CMD_WAKE);
    rdchk("wk_cyl", seek_ctl_pkg::OFS_CYL, 32'hFF, 32'h0);
    rdchk("wk_st0", seek_ctl_pkg::OFS_STATUS0, 32'hFF, 32'h0);
    rdchk("wk_st1", seek_ctl_pkg::OFS_STATUS1, 32'hFF, 32'h0);
    rdchk("wk_flg", seek_ctl_pkg::OFS_FLAGS, 32'hF, 32'h0);
    // Read-only status, unmapped place, masked byte lane
    bus(1'b1, seek_ctl_pkg::OFS_STATUS0, 32'hFF);
    rdchk("ro", seek_ctl_pkg::OFS_STATUS0, 32'hFF, 32'h0);
    rdchk("unmap", 5'h02, 32'hFFFFFFFF, 32'h0);
    be <= 4'h0;
    bus(1'b1, seek_ctl_pkg::OFS_TARGET, 32'h33);
    be <= 4'hF;
    rdchk("lane", seek_ctl_pkg::OFS_TARGET, 32'hFF, 32'h9);
    // Reset in mid-move stops the step at once
    cmd(seek_ctl_pkg::CMD_SEEK);
    repeat (4) @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    check("mr", {step, irq, dir}, 32'h0);
    // Gap lengths are fixed by the package: 40 and 26 fill bytes
    // Preamble stream with a consumer that stalls every other cycle
    fstart <= 1'b1;
    @(posedge mclk_i);
    fstart <= 1'b0;
    k = 0;
    t = 0;
    while (k < 80 && t < 400) begin
      @(posedge mclk_i);
      t++;
      if (fvalid === 1'b1 && fready === 1'b1) begin
        check("fmt", fbyte, k < 40 || (k > 46 && k < 73) ? 8'hFF :
          k == 46 ? 8'hFC : k == 79 ? 8'hFE : 8'h00);
        k++;
      end
      fready <= ~fready;
    end
    @(posedge mclk_i);
    check("fmt_end", {k, fvalid}, {32'd80, 1'b0});
    results();
  end
endmodule
